// ==== hdl/mpt_top.sv ====
/*
  Match based PWM timer: prescaled 32-bit counter, seven match registers,
  six PWM outputs, four capture inputs, interrupt status and mask.
  Assumes an AXI4-Lite master on clk_sys and asynchronous capture pins.
*/
`timescale 1ns/1ps
`include "mpt_cfg.svh"
module mpt_top
  import mpt_pkg::*;
#(
  parameter int NM = 7, // Match registers.
  parameter int NC = 4  // Capture inputs.
) (
  // Clock and reset.
  input  wire logic          clk_sys,
  input  wire logic          reset,
  // AXI4-Lite write channels.
  input  wire logic          awvalid,
  output      logic          awready,
  input  wire logic [7:0]    awaddr,
  input  wire logic [2:0]    awprot,
  input  wire logic          wvalid,
  output      logic          wready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  output      logic          bvalid,
  input  wire logic          bready,
  output      logic [1:0]    bresp,
  // AXI4-Lite read channels.
  input  wire logic          arvalid,
  output      logic          arready,
  input  wire logic [7:0]    araddr,
  input  wire logic [2:0]    arprot,
  output      logic          rvalid,
  input  wire logic          rready,
  output      logic [31:0]   rdata,
  output      logic [1:0]    rresp,
  // Timer pins.
  input  wire logic [NC-1:0] cap_in,
  output      logic [NM-2:0] pwm_out,
  // Interrupt.
  output      logic          irq
);
  // ==========================================================================
  // Storage
  mpt_reg_if   rb ();
  logic [2:0]       ctrl_q;             // Enable, hold-clear, PWM mode.
  logic [11:0]      stat_q;             // Pending flags.
  logic [11:0]      mask_q;             // Interrupt mask.
  mpt_word_t        tc_q;               // Timer counter.
  mpt_word_t        pr_q;               // Prescale limit.
  mpt_word_t        pc_q;               // Prescale counter.
  logic [3*NM-1:0]  mctl_q;             // Match actions.
  logic [3*NC-1:0]  cctl_q;             // Capture controls.
  logic [14:0]      pwmc_q;             // Double-edge selects and output enables.
  logic [NM-1:0]    rel_q;              // Released match values waiting.
  mpt_word_t        mshd_q [NM];        // Match values as written.
  mpt_word_t        mact_q [NM];        // Match values in use.
  mpt_word_t        cap_q  [NC];        // Captured counts.
  logic [NM-2:0]    pwm_q;              // PWM output levels.
  logic [NC-1:0]    cap_rise;
  logic [NC-1:0]    cap_fall;

  // ==========================================================================
  // Bus and capture front ends
  mpt_axil_slave u_bus (
    .clk_sys (clk_sys), .reset (reset),
    .awvalid (awvalid), .awready (awready), .awaddr (awaddr),
    .wvalid  (wvalid),  .wready  (wready),  .wdata  (wdata), .wstrb (wstrb),
    .bvalid  (bvalid),  .bready  (bready),  .bresp  (bresp),
    .arvalid (arvalid), .arready (arready), .araddr (araddr),
    .rvalid  (rvalid),  .rready  (rready),  .rdata  (rdata), .rresp (rresp),
    .rb      (rb)
  );

  mpt_capture_sync #(.N(NC)) u_cap (
    .clk_sys (clk_sys), .reset (reset), .pins (cap_in),
    .rise    (cap_rise), .fall (cap_fall)
  );

  // ==========================================================================
  // Address decode
  wire [7:0] wa       = rb.wr_addr;
  wire [2:0] w_idx    = wa[4:2];
  wire [2:0] r_idx    = rb.rd_addr[4:2];
  wire       wr_ctrl  = rb.wr_en && wa == `MPT_CTRL_OFS;
  wire       wr_stat  = rb.wr_en && wa == `MPT_STAT_OFS;
  wire       wr_mask  = rb.wr_en && wa == `MPT_MASK_OFS;
  wire       wr_presc = rb.wr_en && wa == `MPT_PRESC_OFS;
  wire       wr_mctl  = rb.wr_en && wa == `MPT_MCTL_OFS;
  wire       wr_cctl  = rb.wr_en && wa == `MPT_CCTL_OFS;
  wire       wr_pwmc  = rb.wr_en && wa == `MPT_PWMC_OFS;
  wire       wr_rel   = rb.wr_en && wa == `MPT_REL_OFS;
  wire       wr_match = rb.wr_en && wa[7:5] == `MPT_MATCH_OFS >> 5 && int'(w_idx) < NM;
  wire       r_match  = rb.rd_addr[7:5] == `MPT_MATCH_OFS >> 5 && int'(r_idx) < NM;
  wire       r_capt   = rb.rd_addr[7:5] == `MPT_CAPT_OFS >> 5 && int'(r_idx) < NC;
  wire       wr_count = rb.wr_en && wa == `MPT_COUNT_OFS;
  wire       wr_pcnt  = rb.wr_en && wa == `MPT_PCNT_OFS;
  wire       wr_capt  = rb.wr_en && wa[7:5] == `MPT_CAPT_OFS >> 5 && int'(w_idx) < NC;
  // Count, prescale count and captures are read only; a write there is accepted and dropped.
  assign rb.wr_hit = wr_ctrl | wr_stat | wr_mask | wr_presc | wr_mctl | wr_cctl | wr_pwmc
                   | wr_rel | wr_match | wr_count | wr_pcnt | wr_capt;
  wire [31:0] wval  = rb.wr_data;

  // Read data selection; unmapped addresses read zero and answer an error.
  always_comb
  begin
    rb.rd_hit  = 1'b1;
    rb.rd_data = `MPT_RST_WORD;
    if (rb.rd_addr == `MPT_CTRL_OFS)       rb.rd_data = 32'(ctrl_q);
    else if (rb.rd_addr == `MPT_STAT_OFS)  rb.rd_data = 32'(stat_q);
    else if (rb.rd_addr == `MPT_MASK_OFS)  rb.rd_data = 32'(mask_q);
    else if (rb.rd_addr == `MPT_COUNT_OFS) rb.rd_data = tc_q;
    else if (rb.rd_addr == `MPT_PRESC_OFS) rb.rd_data = pr_q;
    else if (rb.rd_addr == `MPT_PCNT_OFS)  rb.rd_data = pc_q;
    else if (rb.rd_addr == `MPT_MCTL_OFS)  rb.rd_data = 32'(mctl_q);
    else if (rb.rd_addr == `MPT_CCTL_OFS)  rb.rd_data = 32'(cctl_q);
    else if (rb.rd_addr == `MPT_PWMC_OFS)  rb.rd_data = 32'(pwmc_q);
    else if (rb.rd_addr == `MPT_REL_OFS)   rb.rd_data = 32'(rel_q);
    else if (r_match)                      rb.rd_data = mshd_q[r_idx];
    else if (r_capt)                       rb.rd_data = cap_q[r_idx[1:0]];
    else                                   rb.rd_hit  = 1'b0;
  end

  // ==========================================================================
  // Counting and match events
  wire            pwm_mode = ctrl_q[`MPT_CTRL_PWM];
  wire            clr      = ctrl_q[`MPT_CTRL_CLR];
  wire            tick     = ctrl_q[`MPT_CTRL_EN] && !clr && pc_q == pr_q;
  logic [NM-1:0]  hit;                  // Counter equals a match value on a tick.
  logic [NM-1:0]  hit_rst;
  logic [NM-1:0]  hit_stop;
  logic [NM-1:0]  hit_irq;
  logic [NC-1:0]  cap_ev;
  logic [NC-1:0]  cap_irq;

  // Each match compares against its value in use, any count allowed.
  for (genvar i = 0; i < NM; i++)
  begin : g_match
    assign hit[i]      = tick && tc_q == mact_q[i];
    assign hit_rst[i]  = hit[i] && mctl_q[3*i + `MPT_MC_RST];
    assign hit_stop[i] = hit[i] && mctl_q[3*i + `MPT_MC_STOP];
    assign hit_irq[i]  = hit[i] && mctl_q[3*i + `MPT_MC_IRQ];
  end

  // Capture events follow the selected edges, plain timer or PWM mode alike.
  for (genvar c = 0; c < NC; c++)
  begin : g_capt
    assign cap_ev[c]  = (cap_rise[c] && cctl_q[3*c + `MPT_CC_RISE])
                      || (cap_fall[c] && cctl_q[3*c + `MPT_CC_FALL]);
    assign cap_irq[c] = cap_ev[c] && cctl_q[3*c + `MPT_CC_IRQ];
  end

  wire period_hit = pwm_mode && hit[0];
  wire cnt_zero   = |hit_rst || period_hit;
  wire stop_hit   = |hit_stop;
  wire [11:0] ev  = {cap_irq, 1'b0, hit_irq};

  // Prescaler restarts at each tick so the counter advances once per pr_q+1 cycles.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pc_q <= `MPT_RST_WORD;
      tc_q <= `MPT_RST_WORD;
    end
    else if (clr || !ctrl_q[`MPT_CTRL_EN] || tick)
    begin
      pc_q <= `MPT_RST_WORD;
      if (clr)
        tc_q <= `MPT_RST_WORD;
      else if (tick)
        tc_q <= cnt_zero ? `MPT_RST_WORD : tc_q + 32'h0000_0001;
    end
    else
    begin
      pc_q <= pc_q + 32'h0000_0001;
    end
  end

  // Control registers; a stop match clears the enable bit.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrl_q <= 3'h0;
      mask_q <= 12'h000;
      pr_q   <= `MPT_RST_WORD;
      mctl_q <= '0;
      cctl_q <= '0;
      pwmc_q <= 15'h0000;
    end
    else
    begin
      if (wr_ctrl)  ctrl_q <= 3'(mpt_merge(32'(ctrl_q), wval, rb.wr_strb));
      if (stop_hit) ctrl_q[`MPT_CTRL_EN] <= 1'b0;
      if (wr_mask)  mask_q <= 12'(mpt_merge(32'(mask_q), wval, rb.wr_strb));
      if (wr_presc) pr_q   <= mpt_merge(pr_q, wval, rb.wr_strb);
      if (wr_mctl)  mctl_q <= (3*NM)'(mpt_merge(32'(mctl_q), wval, rb.wr_strb));
      if (wr_cctl)  cctl_q <= (3*NC)'(mpt_merge(32'(cctl_q), wval, rb.wr_strb));
      if (wr_pwmc)  pwmc_q <= 15'(mpt_merge(32'(pwmc_q), wval, rb.wr_strb));
    end
  end

  // ==========================================================================
  // Match values: written to the shadow, in use at once in timer mode, moved in use at the period boundary in PWM mode once released
  wire            wr_rel_lo = wr_rel && rb.wr_strb[0];
  wire [NM-1:0]   apply     = period_hit ? rel_q : '0;

  // Release bits are set by software and cleared once applied; a new set wins.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rel_q <= '0;
    else
      rel_q <= (rel_q & ~apply) | (wr_rel_lo ? wval[NM-1:0] : '0);
  end

  // In timer mode writes act at once; in PWM mode only released values move over.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int i = 0; i < NM; i++)
      begin
        mshd_q[i] <= `MPT_RST_WORD;
        mact_q[i] <= `MPT_RST_WORD;
      end
    end
    else
    begin
      for (int i = 0; i < NM; i++)
      begin
        if (apply[i])
          mact_q[i] <= mshd_q[i];
        else if (wr_match && int'(w_idx) == i && !pwm_mode)
          mact_q[i] <= mpt_merge(mshd_q[i], wval, rb.wr_strb);
      end
      if (wr_match)
        mshd_q[w_idx] <= mpt_merge(mshd_q[w_idx], wval, rb.wr_strb);
    end
  end

  // ==========================================================================
  // Captures and pending flags
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int c = 0; c < NC; c++)
        cap_q[c] <= `MPT_RST_WORD;
      stat_q <= 12'h000;
    end
    else
    begin
      for (int c = 0; c < NC; c++)
        if (cap_ev[c]) cap_q[c] <= tc_q;
      // A flag raised in the cycle it is cleared stays set.
      stat_q <= (stat_q & ~(wr_stat ? 12'(mpt_merge('0, wval, rb.wr_strb)) : 12'h000))
              | ev;
    end
  end

  assign irq = |(stat_q & mask_q);

  // ==========================================================================
  // PWM outputs: output n rises on match n when double-edged, else on the period
  for (genvar n = 0; n < NM - 1; n++)
  begin : g_pwm
    wire dbl  = pwmc_q[n + 1];
    wire set  = dbl ? hit[n] : hit[0];
    wire fall = hit[n + 1];
    wire on   = pwm_mode && pwmc_q[`MPT_PWMC_EN + n + 1];
    always_ff @(posedge clk_sys)
    begin
      if (reset)
        pwm_q[n] <= 1'b0;
      else
        pwm_q[n] <= on && ((pwm_q[n] || set) && !fall);
    end
  end

  assign pwm_out = pwm_q;

  // ==========================================================================
  // Checks
  count_step_a: assert property (@(posedge clk_sys) disable iff (reset)
    tick && !cnt_zero |=> tc_q == $past(tc_q) + 32'h0000_0001)
    else $error("Counter did not advance by one on a tick.");
  count_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    !tick && !clr |=> $stable(tc_q))
    else $error("Counter moved without a tick.");
  match_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
    |hit_rst |=> tc_q == `MPT_RST_WORD)
    else $error("Reset-on-match did not zero the counter.");
  match_stop_a: assert property (@(posedge clk_sys) disable iff (reset)
    stop_hit |=> !ctrl_q[`MPT_CTRL_EN] ##1 $stable(tc_q))
    else $error("Stop-on-match did not halt the counter.");
  period_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
    period_hit |=> tc_q == `MPT_RST_WORD)
    else $error("Period match did not restart the cycle.");
  single_rise_a: assert property (@(posedge clk_sys) disable iff (reset)
    pwm_mode && pwmc_q[`MPT_PWMC_EN + 1] && !pwmc_q[1] && hit[0] && !hit[1] |=> pwm_q[0])
    else $error("Single-edge output did not rise at the period match.");
  edge_fall_a: assert property (@(posedge clk_sys) disable iff (reset)
    hit[2] |=> !pwm_q[1])
    else $error("Output did not fall at its match.");
  release_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    pwm_mode && !period_hit |=> $stable(mact_q[1]))
    else $error("Match value in use changed away from the period boundary.");
  capture_latch_a: assert property (@(posedge clk_sys) disable iff (reset)
    cap_ev[0] |=> cap_q[0] == $past(tc_q))
    else $error("Capture did not latch the counter.");
  flag_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    hit_irq[0] |=> stat_q[0] ##0 (irq == mask_q[0] || irq))
    else $error("Match event did not set its pending flag.");
endmodule : mpt_top

// ==== hdl/mpt_cfg.svh ====
/*
  Register offsets, field positions and reset values of the match based PWM timer.
  Assumes byte addresses on an 8-bit register window, one 32-bit word per register.
*/
`ifndef MPT_CFG_SVH
`define MPT_CFG_SVH
// ==========================================================================
// Register offsets
`define MPT_CTRL_OFS  8'h00
`define MPT_STAT_OFS  8'h04
`define MPT_MASK_OFS  8'h08
`define MPT_COUNT_OFS 8'h0C
`define MPT_PRESC_OFS 8'h10
`define MPT_PCNT_OFS  8'h14
`define MPT_MCTL_OFS  8'h18
`define MPT_CCTL_OFS  8'h1C
`define MPT_PWMC_OFS  8'h20
`define MPT_REL_OFS   8'h24
`define MPT_MATCH_OFS 8'h40
`define MPT_CAPT_OFS  8'h60
// ==========================================================================
// Field positions
`define MPT_CTRL_EN   0
`define MPT_CTRL_CLR  1
`define MPT_CTRL_PWM  2
`define MPT_MC_IRQ    0
`define MPT_MC_RST    1
`define MPT_MC_STOP   2
`define MPT_CC_RISE   0
`define MPT_CC_FALL   1
`define MPT_CC_IRQ    2
`define MPT_ST_CAP    8
`define MPT_PWMC_EN   8
// ==========================================================================
// Reset values
`define MPT_RST_WORD  32'h0000_0000
`endif

// ==== hdl/mpt_pkg.sv ====
/*
  Types and shared helpers of the match based PWM timer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mpt_pkg;
  // A register word.
  typedef logic [31:0] mpt_word_t;

  // Merges a write into a register word under its byte strobes.
  function automatic mpt_word_t mpt_merge(input mpt_word_t old_v, input mpt_word_t new_v,
                                          input logic [3:0] strb);
    mpt_word_t res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : mpt_merge
endpackage : mpt_pkg

// ==== hdl/mpt_reg_if.sv ====
/*
  Carrier between the bus slave and the register file of the PWM timer.
  Assumes one clock; strobes last one cycle.
*/
`timescale 1ns/1ps
interface mpt_reg_if;
  logic        wr_en;   // One-cycle write strobe.
  logic [7:0]  wr_addr; // Write byte address.
  logic [31:0] wr_data; // Write data.
  logic [3:0]  wr_strb; // Write byte strobes.
  logic        wr_hit;  // Write address is mapped.
  logic        rd_en;   // One-cycle read strobe.
  logic [7:0]  rd_addr; // Read byte address.
  logic [31:0] rd_data; // Read data, valid with rd_en.
  logic        rd_hit;  // Read address is mapped.
  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                input wr_hit, rd_data, rd_hit);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface : mpt_reg_if

// ==== hdl/mpt_axil_slave.sv ====
/*
  AXI4-Lite slave that turns bus transfers into one-cycle register strobes.
  Assumes the register file answers hit and read data combinationally.
*/
`timescale 1ns/1ps
module mpt_axil_slave
  import mpt_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Write channels.
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output      logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output      logic        bvalid,
  input  wire logic        bready,
  output      logic [1:0]  bresp,
  // Read channels.
  input  wire logic        arvalid,
  output      logic        arready,
  input  wire logic [7:0]  araddr,
  output      logic        rvalid,
  input  wire logic        rready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  // Register side.
  mpt_reg_if.bus           rb
);
  logic        aw_full_q; // Write address held.
  logic        w_full_q;  // Write data held.
  logic [7:0]  aw_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  wire         aw_take = awvalid && awready;
  wire         w_take  = wvalid && wready;
  wire         ar_take = arvalid && arready;

  // Address and data are taken in either order; the strobe fires once both are held.
  assign awready    = !aw_full_q && !bvalid;
  assign wready     = !w_full_q && !bvalid;
  assign arready    = !rvalid;
  assign rb.wr_en   = aw_full_q && w_full_q && !bvalid;
  assign rb.wr_addr = aw_q;
  assign rb.wr_data = wd_q;
  assign rb.wr_strb = ws_q;
  assign rb.rd_en   = ar_take;
  assign rb.rd_addr = araddr;

  // Write path: hold address and data, then answer with a response.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_q      <= 8'h00;
      wd_q      <= 32'h0000_0000;
      ws_q      <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= 2'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full_q <= 1'b1;
        aw_q      <= awaddr;
      end
      if (w_take)
      begin
        w_full_q <= 1'b1;
        wd_q     <= wdata;
        ws_q     <= wstrb;
      end
      if (rb.wr_en)
      begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= rb.wr_hit ? 2'h0 : 2'h2;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read path: data are captured with the address and held until taken.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'h0;
    end
    else if (ar_take)
    begin
      rvalid <= 1'b1;
      rdata  <= rb.rd_data;
      rresp  <= rb.rd_hit ? 2'h0 : 2'h2;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
    end
  end
endmodule : mpt_axil_slave

// ==== hdl/mpt_capture_sync.sv ====
/*
  Synchronises the capture pins and reports their edges as one-cycle pulses.
  Assumes the pins are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module mpt_capture_sync #(
  parameter int N = 4
) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // Pins and edge pulses.
  input  wire logic [N-1:0] pins,
  output      logic [N-1:0] rise,
  output      logic [N-1:0] fall
);
  logic [N-1:0] meta_q; // First stage, read only by sync_q.
  logic [N-1:0] sync_q; // Second stage.
  logic [N-1:0] last_q; // Previous synchronised level.

  // Two flip-flops, then a third to compare against.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end
    else
    begin
      meta_q <= pins;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule : mpt_capture_sync

// ==== testbench/test_match_based_pwm_timer.sv ====
/*
  Bench of the PWM timer: bus, PWM widths, release, timer, capture, irq.
  Assumes mpt_top and mpt_cfg.svh are compiled before this file.
*/
`timescale 1ns/1ps
`include "mpt_cfg.svh"
module test_match_based_pwm_timer;
  // ======================================================================
  // Signals.
  logic        clk_sys, reset, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv, c0;
  logic [3:0]  cap_in;
  logic [5:0]  pwm_out;
  logic [1:0]  bresp, rresp, br, rr;
  int          n_errors, num_checks, seed, pl;
  int          m[7], mo[7];

  mpt_top u_dut (.clk_sys, .reset, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .cap_in,
    .pwm_out, .irq);

  // Free running 200 MHz clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Watchdog; the whole run needs well under 20000 cycles.
  initial
  begin
    #100000;
    n_errors++;
    stop_test();
  end

  // ======================================================================
  // Tasks.
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // AXI write: both channels offered together, each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, dn;
    {aw, w, dn} = 3'b110;
    // One edge between transfers, so no strobe is assigned twice in a step.
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    while (!dn)
    begin
      @(negedge clk_sys);
      {dn, br} = {bvalid, bresp};
      aw = aw && !awready;
      w = w && !wready;
      @(posedge clk_sys);
      {awvalid, wvalid} <= {aw, w};
    end
    bready <= 1'b0;
  endtask : wr

  // AXI read: data and response are taken at the first negedge that sees rvalid.
  task automatic rd(input logic [7:0] a);
    logic ar, dn;
    {ar, dn} = 2'b10;
    // One edge between transfers, so no strobe is assigned twice in a step.
    @(posedge clk_sys);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    while (!dn)
    begin
      @(negedge clk_sys);
      {dn, rv, rr} = {rvalid, rdata, rresp};
      ar = ar && !arready;
      @(posedge clk_sys);
      arvalid <= ar;
    end
    rready <= 1'b0;
  endtask : rd

  // High counter steps of output n per period; clear wins over set.
  function automatic int hexp(input int n, input int v[7]);
    logic d;
    int s;
    d = (n == 2 || n == 4);
    s = d ? v[n-1] : v[0];
    if (v[n] == s)
      return 0;
    return (v[n] - s + v[0] + 1) % (v[0] + 1);
  endfunction : hexp

  // Counts high cycles of every output over one period and compares.
  task automatic cmp_pwm(input int v[7]);
    int h[6];
    h = '{default: 0};
    repeat ((v[0] + 1) * (pl + 1))
    begin
      @(negedge clk_sys);
      foreach (h[i]) h[i] += (pwm_out[i] === 1'b1);
    end
    @(posedge clk_sys);
    for (int n = 1; n < 7; n++)
      chk("pwm_high", h[n-1], hexp(n, v) * (pl + 1));
  endtask : cmp_pwm

  // ======================================================================
  // Main sequence.
  initial
  begin
    seed = 32'hFFD7;
    {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, cap_in} = {48'h0, 4'h2};
    {n_errors, num_checks} = 64'h0;
    mo = '{default: 0};
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(`MPT_CTRL_OFS);
    chk("ctrl_reset", rv, `MPT_RST_WORD);
    wr(8'h30, 32'h1);
    chk("bresp_unmapped", br, 2'h2);
    rd(8'h30);
    chk("rresp_unmapped", rr, 2'h2);
    $display("test reset done");
    // Random periods and edges, old values kept until released.
    pl = $unsigned($random(seed)) % 3;
    wr(`MPT_PRESC_OFS, pl);
    wr(`MPT_PWMC_OFS, 32'h7E14);
    wr(`MPT_CTRL_OFS, 32'h5);
    repeat (4)
    begin
      m[0] = 4 + $unsigned($random(seed)) % 30;
      for (int i = 1; i < 7; i++)
        m[i] = $unsigned($random(seed)) % (m[0] + 1);
      for (int i = 0; i < 7; i++)
        wr(8'(`MPT_MATCH_OFS + 4 * i), m[i]);
      cmp_pwm(mo);
      wr(`MPT_REL_OFS, 32'h7F);
      repeat ((mo[0] + m[0] + 3) * (pl + 1)) @(posedge clk_sys);
      rd(`MPT_REL_OFS);
      chk("release_done", rv, 32'h0);
      cmp_pwm(m);
      mo = m;
    end
    $display("test pwm done");
    // Timer mode: continue with irq on match 0, stop on match 2.
    wr(`MPT_CTRL_OFS, 32'h2);
    wr(`MPT_MCTL_OFS, 32'h141);
    wr(`MPT_MATCH_OFS, 32'h7);
    wr(8'h48, 32'h14);
    wr(`MPT_CTRL_OFS, 32'h1);
    repeat (30 * (pl + 1)) @(posedge clk_sys);
    rd(`MPT_CTRL_OFS);
    chk("stop_clears_en", rv, 32'h0);
    rd(`MPT_COUNT_OFS);
    chk("stop_count", rv - 32'h14 < 2, 1'b1);
    rd(`MPT_STAT_OFS);
    chk("match_flags", rv, 32'h5);
    chk("irq_masked", irq, 1'b0);
    wr(`MPT_MASK_OFS, 32'h4);
    chk("irq_on", irq, 1'b1);
    wr(`MPT_STAT_OFS, 32'h4);
    rd(`MPT_STAT_OFS);
    chk("w1c", rv, 32'h1);
    chk("irq_off", irq, 1'b0);
    wr(`MPT_STAT_OFS, 32'h1);
    $display("test timer done");
    // Rise on capture 0 and fall on capture 1 at the same time.
    wr(`MPT_MCTL_OFS, 32'h0);
    wr(`MPT_CCTL_OFS, 32'h35);
    wr(`MPT_CTRL_OFS, 32'h1);
    rd(`MPT_COUNT_OFS);
    c0 = rv;
    cap_in <= 4'h1;
    repeat (8) @(posedge clk_sys);
    for (int c = 0; c < 2; c++)
    begin
      rd(8'(`MPT_CAPT_OFS + 4 * c));
      chk("capture", rv - c0 < 11, 1'b1);
    end
    rd(8'h68);
    chk("capture_idle", rv, 32'h0);
    rd(`MPT_STAT_OFS);
    chk("capture_flags", rv, 32'h300);
    $display("test capture done");
    stop_test();
  end
endmodule : test_match_based_pwm_timer
